// [pss_sequencer.sv]
`timescale 1ns/1ps
// What this block does
// - io rail reference reaches its level within about 25 ms of request.
// - command interface becomes ready about 25 s after the power-on request.
// - clear-to-send falls high to low at readiness; host waits for it.
// - on usb, communication starts only after enumeration has completed.
// - setting 0: awake while dtr low, sleep after dtr high a while.
// - setting 1: sleep when idle, wake on a character, drop that character.
// - setting 2: never sleep, whatever dtr or serial activity.
// - sleep configuration accepted only from the first serial port.
// - either power-off command gives an orderly switch-off.
// - fast shutdown input shuts down without network deregistration.
// - wake request high blocks sleep and off, and wakes from them.
module pss_sequencer #(
    parameter logic [29:0] RAIL_CYC  = pss_pkg::RAIL_UP_CYC,
    parameter logic [29:0] READY_CYC = pss_pkg::CMD_READY_CYC,
    parameter logic [29:0] SLEEP_CYC = pss_pkg::SLEEP_DELAY_CYC
) (
    // clock and reset
    input  wire logic              CORE_CLK,
    input  wire logic              RST_N,
    // asynchronous pins
    input  wire logic              POWER_ON_REQUEST_N,
    input  wire logic              DTR_N,
    input  wire logic              WAKE_REQUEST,
    input  wire logic              FAST_SHUTDOWN,
    // same-clock inputs from the core
    input  wire pss_pkg::pss_cmd_s CMD,
    input  wire logic              TASKS_IDLE,
    input  wire logic              RX_CHAR_SEEN,
    input  wire logic              USB_ENUM_DONE,
    input  wire logic              DEREG_DONE,
    // outputs
    output logic                   IO_RAIL_REFERENCE,
    output logic                   FIRST_SERIAL_CLEAR_TO_SEND,
    output logic                   USB_COMM_ENABLE,
    output logic                   DEREGISTER_REQ,
    output logic                   SLEEPING,
    output logic                   DISCARD_RX_CHAR,
    output logic                   MODULE_HALTED,
    output logic [1:0]             SLEEP_SETTING
);
    import pss_pkg::*;

    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] meta_r;
    logic [SYNC_W-1:0] sync_r;
    pss_state_e        state_r;
    pss_state_e        state_nxt;
    logic [29:0]       cnt_r;
    logic [29:0]       cnt_nxt;
    logic [1:0]        sleep_mode_r;
    logic [1:0]        sleep_mode_nxt;
    logic              por_req;
    logic              dtr_high;
    logic              wake_s;
    logic              fast_s;
    logic              fast_go;
    logic              off_cmd;
    logic              cfg_ok;
    logic              sleep_go;
    logic              sleep_exit;
    logic              keep_cnt;
    logic              ready_nxt;
    logic              discard_nxt;

    assign pins = {POWER_ON_REQUEST_N, DTR_N, WAKE_REQUEST, FAST_SHUTDOWN};

    // two-flop synchronisers; only the second stage is read
    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++)
        begin : g_sync
            always_ff @(posedge CORE_CLK or negedge RST_N)
            begin
                if (!RST_N)
                begin
                    meta_r[g] <= SYNC_RST[g];
                    sync_r[g] <= SYNC_RST[g];
                end
                else
                begin
                    meta_r[g] <= pins[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    // decoded levels and events
    assign por_req  = !sync_r[SYNC_POR_N];
    assign dtr_high = sync_r[SYNC_DTR_N];
    assign wake_s   = sync_r[SYNC_WAKE];
    assign fast_s   = sync_r[SYNC_FAST];
    // wake request holds the module out of off mode
    assign fast_go  = fast_s && !wake_s;
    assign off_cmd  = CMD.valid &&
                      (CMD.code == PSS_CMD_OFF || CMD.code == PSS_CMD_OFF_ALT);
    // other ports and out-of-range settings are ignored
    assign cfg_ok   = CMD.valid && CMD.code == PSS_CMD_SLEEP_CFG &&
                      CMD.from_first_serial && CMD.sleep_arg != 2'h3;
    assign sleep_mode_nxt = cfg_ok ? CMD.sleep_arg : sleep_mode_r;

    // sleep entry per setting; setting 2 never matches
    // at-or-above, since the count may already be past the limit when setting 0 arrives
    assign sleep_go = !wake_s && (
        (sleep_mode_r == SLEEP_DTR && dtr_high && cnt_r >= SLEEP_CYC - 30'h1) ||
        (sleep_mode_r == SLEEP_AUTO && TASKS_IDLE));
    // any wake source ends sleep
    assign sleep_exit = wake_s || sleep_mode_r == SLEEP_NEVER ||
        (sleep_mode_r == SLEEP_DTR && !dtr_high) ||
        (sleep_mode_r == SLEEP_AUTO && RX_CHAR_SEEN);

    // next state; fast shutdown outranks everything but a held wake
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            PSS_OFF:
                if (por_req)
                    state_nxt = PSS_RAIL;
            PSS_RAIL:
                if (fast_go)
                    state_nxt = PSS_HALT;
                else if (cnt_r == RAIL_CYC - 30'h1)
                    state_nxt = PSS_BOOT;
            PSS_BOOT:
                if (fast_go)
                    state_nxt = PSS_HALT;
                else if (cnt_r == READY_CYC - 30'h1)
                    state_nxt = PSS_ACTIVE;
            PSS_ACTIVE:
                if (fast_go)
                    state_nxt = PSS_HALT;
                else if (off_cmd)
                    state_nxt = PSS_DEREG;
                else if (sleep_go)
                    state_nxt = PSS_SLEEP;
            PSS_SLEEP:
                if (fast_go)
                    state_nxt = PSS_HALT;
                else if (off_cmd)
                    state_nxt = PSS_DEREG;
                else if (sleep_exit)
                    state_nxt = PSS_ACTIVE;
            PSS_DEREG:
                if (fast_go || (DEREG_DONE && !wake_s))
                    state_nxt = PSS_HALT;
            PSS_HALT:
                if (wake_s)
                    state_nxt = PSS_RAIL;
            default:
                state_nxt = PSS_OFF;
        endcase
    end

    // one counter: from the request through boot, then dtr-high time
    assign keep_cnt = (state_r == state_nxt) ||
                      (state_r == PSS_RAIL && state_nxt == PSS_BOOT);
    assign cnt_nxt  = (!keep_cnt || (state_r == PSS_ACTIVE && !dtr_high)) ? 30'h0 :
                      (cnt_r == 30'h3FFFFFFF) ? cnt_r : cnt_r + 30'h1;

    assign ready_nxt   = state_nxt == PSS_ACTIVE || state_nxt == PSS_SLEEP ||
                         state_nxt == PSS_DEREG;
    // the waking character is dropped, not passed up
    assign discard_nxt = state_r == PSS_SLEEP && state_nxt == PSS_ACTIVE &&
                         sleep_mode_r == SLEEP_AUTO && RX_CHAR_SEEN && !wake_s;

    // state, counter and setting
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_r      <= PSS_OFF;
            cnt_r        <= 30'h0;
            sleep_mode_r <= SLEEP_RST;
        end
        else
        begin
            state_r      <= state_nxt;
            cnt_r        <= cnt_nxt;
            sleep_mode_r <= sleep_mode_nxt;
        end
    end

    // registered outputs, taken from the next state to save a cycle
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            IO_RAIL_REFERENCE          <= 1'b0;
            FIRST_SERIAL_CLEAR_TO_SEND <= 1'b1;
            USB_COMM_ENABLE            <= 1'b0;
            DEREGISTER_REQ             <= 1'b0;
            SLEEPING                   <= 1'b0;
            DISCARD_RX_CHAR            <= 1'b0;
            MODULE_HALTED              <= 1'b0;
        end
        else
        begin
            IO_RAIL_REFERENCE          <= ready_nxt || state_nxt == PSS_BOOT;
            FIRST_SERIAL_CLEAR_TO_SEND <= !ready_nxt;
            USB_COMM_ENABLE            <= ready_nxt && USB_ENUM_DONE;
            DEREGISTER_REQ             <= state_nxt == PSS_DEREG;
            SLEEPING                   <= state_nxt == PSS_SLEEP;
            DISCARD_RX_CHAR            <= discard_nxt;
            MODULE_HALTED              <= state_nxt == PSS_HALT;
        end
    end

    assign SLEEP_SETTING = sleep_mode_r;

    // rail comes up exactly at the end of its count
    a_rail_up_time: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_r == PSS_RAIL && cnt_r == RAIL_CYC - 30'h1 && !fast_go)
        |=> IO_RAIL_REFERENCE)
        else $error("io rail late");

    a_ready_time: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        $fell(FIRST_SERIAL_CLEAR_TO_SEND) |-> $past(cnt_r) == READY_CYC - 30'h1)
        else $error("ready at wrong count");

    a_cts_low_ready: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_r == PSS_ACTIVE) |-> !FIRST_SERIAL_CLEAR_TO_SEND && IO_RAIL_REFERENCE)
        else $error("cts high while ready");

    a_usb_after_enum: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        USB_COMM_ENABLE |-> $past(USB_ENUM_DONE) && !FIRST_SERIAL_CLEAR_TO_SEND)
        else $error("usb talk before enumeration");

    a_dtr_wake: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_r == PSS_SLEEP && sleep_mode_r == SLEEP_DTR && !dtr_high && !fast_go
         && !off_cmd) |=> state_r == PSS_ACTIVE && !SLEEPING)
        else $error("dtr low did not wake");

    a_char_dropped: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_r == PSS_SLEEP && sleep_mode_r == SLEEP_AUTO && RX_CHAR_SEEN && !wake_s
         && !fast_go && !off_cmd) |=> DISCARD_RX_CHAR ##1 !DISCARD_RX_CHAR)
        else $error("waking char not dropped");

    a_never_sleep: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_r == PSS_ACTIVE && sleep_mode_r == SLEEP_NEVER) |=> !SLEEPING)
        else $error("slept with setting 2");

    a_cfg_port_only: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CMD.valid && !CMD.from_first_serial) |=> $stable(sleep_mode_r))
        else $error("setting changed from wrong port");

    a_orderly_off: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_r == PSS_ACTIVE && off_cmd && !fast_go) |=> DEREGISTER_REQ)
        else $error("off command skipped deregistration");

    a_fast_no_dereg: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (fast_go && state_r != PSS_OFF && state_r != PSS_HALT)
        |=> MODULE_HALTED && !DEREGISTER_REQ)
        else $error("fast shutdown misbehaved");

    a_wake_holds_on: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        wake_s |=> !SLEEPING && !MODULE_HALTED)
        else $error("slept or halted with wake high");

    a_sync_depth: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        ##2 (fast_s == $past(FAST_SHUTDOWN, 2)))
        else $error("fast shutdown not two flops deep");

endmodule

// [pss_pkg.sv]
package pss_pkg;

    // core clock
    localparam int unsigned CLK_HZ = 40_000_000;

    // io rail comes up within this long of the power-on request
    localparam int unsigned RAIL_UP_TIME_MS = 25;
    // command interface ready this long after the power-on request
    localparam int unsigned CMD_READY_TIME_S = 25;
    // dtr must stay high this long before sleep is taken
    localparam int unsigned SLEEP_DELAY_TIME_US = 1000;

    // cycle counts; the longest time rounds down, the least times round up
    localparam logic [29:0] RAIL_UP_CYC = 30'(RAIL_UP_TIME_MS * (CLK_HZ / 1000));
    localparam logic [29:0] CMD_READY_CYC = 30'(CMD_READY_TIME_S * CLK_HZ);
    localparam logic [29:0] SLEEP_DELAY_CYC =
        30'((SLEEP_DELAY_TIME_US * (CLK_HZ / 1000) + 999) / 1000);

    // synchroniser layout and reset values: request_n, dtr_n, wake, fast
    localparam int unsigned SYNC_W = 4;
    localparam int unsigned SYNC_POR_N = 3;
    localparam int unsigned SYNC_DTR_N = 2;
    localparam int unsigned SYNC_WAKE = 1;
    localparam int unsigned SYNC_FAST = 0;
    localparam logic [3:0] SYNC_RST = 4'hC;

    // sleep settings and the value after reset
    localparam logic [1:0] SLEEP_DTR = 2'h0;
    localparam logic [1:0] SLEEP_AUTO = 2'h1;
    localparam logic [1:0] SLEEP_NEVER = 2'h2;
    localparam logic [1:0] SLEEP_RST = 2'h2;

    typedef enum logic [1:0] {
        PSS_CMD_NONE      = 2'h0,
        PSS_CMD_SLEEP_CFG = 2'h1,
        PSS_CMD_OFF       = 2'h2,
        PSS_CMD_OFF_ALT   = 2'h3
    } pss_cmd_e;

    // decoded command from the command parser
    typedef struct packed {
        logic       valid;
        pss_cmd_e   code;
        logic       from_first_serial;
        logic [1:0] sleep_arg;
    } pss_cmd_s;

    // gray along off, rail, boot, active, sleep
    typedef enum logic [2:0] {
        PSS_OFF    = 3'h0,
        PSS_RAIL   = 3'h1,
        PSS_BOOT   = 3'h3,
        PSS_ACTIVE = 3'h2,
        PSS_SLEEP  = 3'h6,
        PSS_DEREG  = 3'h7,
        PSS_HALT   = 3'h4
    } pss_state_e;

endpackage

// [pss_host_model.sv]
`timescale 1ns/1ps
module pss_host_model #(
    parameter int SUPPLY_CYC = 20
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // bench requests
    input  wire logic go,
    input  wire logic want_wake,
    // device side
    input  wire logic cts,
    output logic      pull_en,
    output logic      dtr_n,
    output logic      ready,
    output logic      supply_on
);
    int   cnt_r;
    logic cts_r;

    // supply first, then pull the request low through the drain stage only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r     <= 0;
            cts_r     <= 1'b1;
            supply_on <= 1'b0;
            pull_en   <= 1'b0;
            ready     <= 1'b0;
            dtr_n     <= 1'b1;
        end
        else
        begin
            cts_r     <= cts;
            supply_on <= go;
            dtr_n     <= !want_wake;
            if (supply_on && !pull_en && !ready && cnt_r < SUPPLY_CYC)
                cnt_r <= cnt_r + 1;
            if (cnt_r == SUPPLY_CYC && !ready)
                pull_en <= 1'b1;
            // no commands until clear-to-send has fallen; then let go of the line
            if (pull_en && cts_r && !cts)
            begin
                ready   <= 1'b1;
                pull_en <= 1'b0;
            end
        end
    end
endmodule

// [tb.sv]
`timescale 1ns/1ps
module tb;
    import pss_pkg::*;
    localparam logic [29:0] RAIL = 30'h00A;
    localparam logic [29:0] RDY  = 30'h032;
    localparam logic [29:0] SLP  = 30'h005;
    logic       clk, rst_n, por_n, wake, fast, idle, rx, enum_done, dereg_done;
    logic       go, want_wake, pull_en, dtr_n, ready, supply_on;
    logic       rail, cts, usb, dereg, slp, disc, halted;
    logic [1:0] setting;
    pss_cmd_s   cmd;
    int         failures, total_checks, n;

    // request line has a pull-up; the host only ever sinks it
    assign por_n = pull_en ? 1'b0 : 1'b1;

    pss_sequencer #(.RAIL_CYC(RAIL), .READY_CYC(RDY), .SLEEP_CYC(SLP)) pss_sequencer_inst (
        .CORE_CLK(clk), .RST_N(rst_n), .POWER_ON_REQUEST_N(por_n), .DTR_N(dtr_n),
        .WAKE_REQUEST(wake), .FAST_SHUTDOWN(fast), .CMD(cmd), .TASKS_IDLE(idle),
        .RX_CHAR_SEEN(rx), .USB_ENUM_DONE(enum_done), .DEREG_DONE(dereg_done),
        .IO_RAIL_REFERENCE(rail), .FIRST_SERIAL_CLEAR_TO_SEND(cts), .USB_COMM_ENABLE(usb),
        .DEREGISTER_REQ(dereg), .SLEEPING(slp), .DISCARD_RX_CHAR(disc),
        .MODULE_HALTED(halted), .SLEEP_SETTING(setting));

    pss_host_model pss_host_model_inst (
        .clk(clk), .rst_n(rst_n), .go(go), .want_wake(want_wake), .cts(cts),
        .pull_en(pull_en), .dtr_n(dtr_n), .ready(ready), .supply_on(supply_on));

    // free-running core clock, 25 ns
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    function automatic logic pick(input int i);
        case (i)
            0: return rail;
            1: return cts;
            2: return slp;
            3: return halted;
            default: return pull_en;
        endcase
    endfunction

    // bounded wait; cnt is edges passed, sampled just after each edge
    task automatic waitfor(input int i, input logic v, input int lim, output int cnt);
        cnt = 0;
        do
        begin
            tick(1);
            cnt++;
        end while (pick(i) !== v && cnt < lim);
    endtask

    task automatic send(input pss_cmd_e c, input logic f, input logic [1:0] a);
        @(posedge clk);
        cmd <= '{1'b1, c, f, a};
        @(posedge clk);
        cmd <= '0;
        #1;
    endtask

    task automatic t_reset();
        check({rail, cts, usb, dereg, slp, disc, halted}, 32'h20);
        check(setting, SLEEP_RST);
        $display("reset test done");
    endtask

    task automatic t_power();
        @(posedge clk);
        go <= 1'b1;
        waitfor(4, 1'b1, 100, n);
        check(supply_on, 1);
        waitfor(0, 1'b1, 30, n);
        check(n >= RAIL + 2 && n <= RAIL + 4, 1);
        waitfor(1, 1'b0, 60, n);
        check(n >= RDY - RAIL - 1 && n <= RDY - RAIL + 1, 1);
        check(usb, 0);
        @(posedge clk);
        enum_done <= 1'b1;
        tick(2);
        check({usb, ready}, 32'h3);
        $display("power test done");
    endtask

    task automatic t_cfg();
        @(posedge clk);
        idle <= 1'b1;
        tick(20);
        check(slp, 0);
        idle <= 1'b0;
        send(PSS_CMD_SLEEP_CFG, 1'b0, SLEEP_DTR);
        check(setting, SLEEP_NEVER);
        send(PSS_CMD_SLEEP_CFG, 1'b1, 2'h3);
        check(setting, SLEEP_NEVER);
        send(PSS_CMD_SLEEP_CFG, 1'b1, SLEEP_DTR);
        check(setting, SLEEP_DTR);
        $display("config test done");
    endtask

    task automatic t_dtr();
        waitfor(2, 1'b1, SLP + 5, n);
        check(slp, 1);
        @(posedge clk);
        want_wake <= 1'b1;
        waitfor(2, 1'b0, 8, n);
        check(n, 4);
        tick(10);
        check(slp, 0);
        wake <= 1'b1;
        want_wake <= 1'b0;
        tick(20);
        check(slp, 0);
        wake <= 1'b0;
        waitfor(2, 1'b1, SLP + 8, n);
        wake <= 1'b1;
        waitfor(2, 1'b0, 6, n);
        check(n, 3);
        wake <= 1'b0;
        $display("dtr test done");
    endtask

    task automatic t_auto();
        send(PSS_CMD_SLEEP_CFG, 1'b1, SLEEP_AUTO);
        @(posedge clk);
        idle <= 1'b1;
        waitfor(2, 1'b1, 4, n);
        check(n <= 2, 1);
        idle <= 1'b0;
        rx <= 1'b1;
        @(posedge clk);
        rx <= 1'b0;
        #1;
        check({slp, disc}, 32'h1);
        tick(1);
        check(disc, 0);
        $display("auto sleep test done");
    endtask

    // both power-off codes, each followed by a wake-up from halt
    task automatic t_off();
        for (int i = 0; i < 2; i++)
        begin
            send(i == 0 ? PSS_CMD_OFF : PSS_CMD_OFF_ALT, 1'b1, 2'h0);
            check({dereg, halted}, 32'h2);
            dereg_done <= 1'b1;
            tick(1);
            check({dereg, halted, rail, cts}, 32'h5);
            dereg_done <= 1'b0;
            wake <= 1'b1;
            waitfor(1, 1'b0, 80, n);
            check({halted, cts}, 32'h0);
            wake <= 1'b0;
        end
        $display("off test done");
    endtask

    task automatic t_fast();
        @(posedge clk);
        fast <= 1'b1;
        tick(2);
        check(halted, 0);
        waitfor(3, 1'b1, 4, n);
        check(n, 1);
        check({dereg, rail}, 32'h0);
        $display("fast test done");
    endtask

    // safety net well beyond the expected run length
    initial
    begin
        #(25 * 4000);
        failures++;
        test_done();
    end

    initial
    begin
        failures = 0;
        total_checks = 0;
        rst_n = 1'b0;
        {wake, fast, idle, rx, enum_done, dereg_done, go, want_wake} = '0;
        cmd = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        t_reset();
        t_power();
        t_cfg();
        t_dtr();
        t_auto();
        t_off();
        t_fast();
        test_done();
    end
endmodule
